/* File: design/sinc3_defines.vh */
// constants for the two-channel sinc3 decimator and clocking block
`ifndef SINC3_DEFINES_VH
`define SINC3_DEFINES_VH
// register byte offsets
`define OFS_PRIMARY_CONFIG   8'h00
`define OFS_SECOND_CONFIG    8'h04
`define OFS_THIRD_CONFIG     8'h08
`define OFS_LEADOFF_STATUS   8'h0C
`define OFS_STATUS           8'h10
`define OFS_SAMPLE           8'h14
// field positions
`define PC_DR_LSB            0
`define PC_CLKOUT_EN         5
`define SC_HIGH_REF          5
`define TC_REFBUF_PWR        7
`define LS_CLK_DIV           6
`define CT_START             0
// reset values
`define PRIMARY_RST          8'h02
`define SECOND_RST           8'h80
`define THIRD_RST            8'h00
`define LEADOFF_RST          8'h00
// clock divide
`define DIV_LOW              5'd4
`define DIV_HIGH             5'd16
// settling in output periods
`define SETTLE_PERIODS       2'd3
// saturation codes
`define CODE_POS_FS          16'h7FFF
`define CODE_NEG_FS          16'h8000
`endif

/* File: design/sinc3_channel.v */
// one channel of third-order sinc decimation with clipping to 16 bits
module sinc3_channel #(
   // must exceed 3*log2(N)+1 bits for the largest ratio so the wrap stays harmless
   parameter ACC_W = 32
) (
   // clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // modulator side
   input  wire             mod_en,
   input  wire             mod_bit,
   // decimation control
   input  wire             dec_tick,
   input  wire [4:0]       shift,
   // result
   output reg  [15:0]      result_q
);
`include "sinc3_defines.vh"
   reg  [ACC_W-1:0] i1_q, i2_q, i3_q;
   reg  [ACC_W-1:0] d1_q, d2_q, d3_q;
   wire [ACC_W-1:0] x = mod_bit ? {{(ACC_W-1){1'b0}}, 1'b1} : {ACC_W{1'b1}};
   wire [ACC_W-1:0] c1 = i3_q - d1_q;
   wire [ACC_W-1:0] c2 = c1 - d2_q;
   wire [ACC_W-1:0] c3 = c2 - d3_q;
   // three guard bits let short ratios scale up before the right shift
   wire signed [ACC_W+2:0] wide   = {c3, 3'b000};
   wire signed [ACC_W+2:0] scaled = wide >>> shift;
   reg  [15:0] clip;

   // saturate beyond full scale
   always @* begin
      if (scaled > $signed({{(ACC_W-12){1'b0}}, 15'h7FFF}))
         clip = `CODE_POS_FS;
      else if (scaled < $signed({{(ACC_W-12){1'b1}}, 15'h0000}))
         clip = `CODE_NEG_FS;
      else
         clip = scaled[15:0];
   end

   // cube of the boxcar: three integrators, three combs
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         i1_q     <= {ACC_W{1'b0}};
         i2_q     <= {ACC_W{1'b0}};
         i3_q     <= {ACC_W{1'b0}};
         d1_q     <= {ACC_W{1'b0}};
         d2_q     <= {ACC_W{1'b0}};
         d3_q     <= {ACC_W{1'b0}};
         result_q <= 16'h0000;
      end else begin
         if (mod_en) begin
            i1_q <= i1_q + x;
            i2_q <= i2_q + i1_q;
            i3_q <= i3_q + i2_q;
         end
         if (dec_tick) begin
            d1_q     <= i3_q;
            d2_q     <= c1;
            d3_q     <= c2;
            result_q <= clip;
         end
      end
   end
endmodule // sinc3_channel

/* File: design/sinc3_decimator_clocking.v */
// two-channel sinc3 decimator with clock selection and reference control
// Function
// RULE_01 - modulator rate is master clock divided by 4 or 16.
// RULE_02 - divisor chosen so modulator clock stays at 128 kHz.
// RULE_03 - each channel filtered by third-order sinc, ratio from rate code.
// RULE_04 - one rate code drives every channel identically.
// RULE_05 - step input needs three output periods to settle.
// RULE_06 - first output after start only after filter settling interval.
// RULE_07 - source pin picks clock; output enable bit drives or floats clock pin.
// RULE_08 - master clock 512 kHz or 2.048 MHz via divide bit 6.
// RULE_09 - divide bit resets to 512 kHz setting.
// RULE_10 - host keeps serial clock at most twice master clock.
// RULE_11 - results are 16-bit twos complement, most significant first.
// RULE_12 - results saturate at 7FFF and 8000.
// RULE_13 - one code step is reference over 2^15-1; zero gives 0000.
// RULE_14 - reference buffer power from bit, off after reset.
// RULE_15 - reference 2.42 V default, 4.033 V when high select set.
// RULE_16 - system should stop external clock while powered down.
// RULE_17 - ready output falls low when new results are available.
// RULE_18 - all channel results of one period latched together.
module sinc3_decimator_clocking #(
   parameter NCH   = 2,
   parameter ACC_W = 32
) (
   // system
   input  wire          CLK_SYS,
   input  wire          RST_N,
   // axi4-lite write address
   input  wire [7:0]    S_AXI_AWADDR,
   input  wire          S_AXI_AWVALID,
   output wire          S_AXI_AWREADY,
   // axi4-lite write data
   input  wire [31:0]   S_AXI_WDATA,
   input  wire [3:0]    S_AXI_WSTRB,
   input  wire          S_AXI_WVALID,
   output wire          S_AXI_WREADY,
   // axi4-lite write response
   output reg  [1:0]    S_AXI_BRESP,
   output reg           S_AXI_BVALID,
   input  wire          S_AXI_BREADY,
   // axi4-lite read address
   input  wire [7:0]    S_AXI_ARADDR,
   input  wire          S_AXI_ARVALID,
   output wire          S_AXI_ARREADY,
   // axi4-lite read data
   output reg  [31:0]   S_AXI_RDATA,
   output reg  [1:0]    S_AXI_RRESP,
   output reg           S_AXI_RVALID,
   input  wire          S_AXI_RREADY,
   // clocking
   input  wire          CLOCK_SOURCE_PIN,
   input  wire          MCLK_EXT,
   input  wire          MCLK_INT,
   input  wire          CLK_PIN_I,
   output reg           CLK_PIN_O,
   output reg           CLK_PIN_OE_N,
   // modulator and conversion
   input  wire          START,
   input  wire [NCH-1:0] MOD_BITS,
   // reference control
   output wire          REFBUF_POWER,
   output wire          HIGH_REFERENCE_SELECT,
   // samples and ready
   output reg  [16*NCH-1:0] SAMPLES,
   output reg           CONVERSION_READY_N
);
`include "sinc3_defines.vh"

   ////////////////////////////////////////////////////////////////////////////
   // registers
   reg [7:0] primary_config_register_q;
   reg [7:0] second_config_register_q;
   reg [7:0] third_config_register_q;
   reg [7:0] leadoff_status_register_q;
   reg       sw_start_q;
   reg       aw_held_q;
   reg       w_held_q;
   reg [7:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;

   wire [2:0] data_rate_code  = primary_config_register_q[`PC_DR_LSB+2:`PC_DR_LSB];
   wire       clk_out_en      = primary_config_register_q[`PC_CLKOUT_EN];
   wire       clk_div_sel     = leadoff_status_register_q[`LS_CLK_DIV];

   // RULE_14 buffer power bit
   assign REFBUF_POWER = third_config_register_q[`TC_REFBUF_PWR];
   // RULE_15 reference level
   assign HIGH_REFERENCE_SELECT = second_config_register_q[`SC_HIGH_REF];

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   // no new beat while a response waits, so one write is under way at most
   assign S_AXI_AWREADY = !aw_held_q && !S_AXI_BVALID;
   assign S_AXI_WREADY  = !w_held_q && !S_AXI_BVALID;
   assign S_AXI_ARREADY = !S_AXI_RVALID;

   // a lone address or data beat is parked until its partner arrives
   wire       aw_now = aw_held_q || S_AXI_AWVALID;
   wire       w_now  = w_held_q || S_AXI_WVALID;
   wire [7:0] wa     = aw_held_q ? aw_addr_q : S_AXI_AWADDR;
   wire [31:0] wd    = w_held_q ? w_data_q : S_AXI_WDATA;
   wire [3:0] ws     = w_held_q ? w_strb_q : S_AXI_WSTRB;
   wire       do_wr  = aw_now && w_now && !S_AXI_BVALID;

   // unmapped offsets answer with a slave error and read as zero
   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `OFS_PRIMARY_CONFIG) || (a == `OFS_SECOND_CONFIG) ||
                  (a == `OFS_THIRD_CONFIG) || (a == `OFS_LEADOFF_STATUS) ||
                  (a == `OFS_STATUS) || (a == `OFS_SAMPLE);
      end
   endfunction

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h00000000;
         w_strb_q  <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= 2'b00;
         primary_config_register_q <= `PRIMARY_RST;
         second_config_register_q  <= `SECOND_RST;
         // RULE_14 buffer off at reset
         third_config_register_q   <= `THIRD_RST;
         // RULE_09 512 kHz default
         leadoff_status_register_q <= `LEADOFF_RST;
         sw_start_q <= 1'b0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY && !do_wr) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY && !do_wr) begin
            w_held_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
         end
         if (do_wr) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= mapped(wa) ? 2'b00 : 2'b10;
            // every writable register fits in eight bits, so only the low lane writes
            if (ws[0]) begin
               case (wa)
                  `OFS_PRIMARY_CONFIG: primary_config_register_q <= wd[7:0];
                  `OFS_SECOND_CONFIG:  second_config_register_q  <= wd[7:0];
                  `OFS_THIRD_CONFIG:   third_config_register_q   <= wd[7:0];
                  `OFS_LEADOFF_STATUS: leadoff_status_register_q <= wd[7:0];
                  `OFS_STATUS:         sw_start_q <= wd[`CT_START];
                  default: ;
               endcase
            end
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock selection
   wire ext_mode = !CLOCK_SOURCE_PIN;
   // master clock arrives as a level sampled on CLK_SYS; edges form enables
   // limitation: the master clock must stay well below half the system clock
   reg  mclk_q;
   wire mclk_lvl = ext_mode ? CLK_PIN_I : MCLK_INT;
   wire mclk_rise = mclk_lvl && !mclk_q;

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         mclk_q       <= 1'b0;
         CLK_PIN_O    <= 1'b0;
         // pin floats in reset so a board clock on it never meets a driver
         CLK_PIN_OE_N <= 1'b1;
      end else begin
         mclk_q       <= mclk_lvl;
         // RULE_07 clock pin direction
         CLK_PIN_O    <= MCLK_INT;
         CLK_PIN_OE_N <= !(CLOCK_SOURCE_PIN && clk_out_en);
      end
   end

   // MCLK_EXT is unused; the external clock is taken from CLK_PIN_I
   wire unused_ext = MCLK_EXT;

   ////////////////////////////////////////////////////////////////////////////
   // modulator rate divider
   reg  [4:0] div_cnt_q;
   // RULE_01 RULE_02 RULE_08 divisor from divide bit
   wire [4:0] div_n   = clk_div_sel ? `DIV_HIGH : `DIV_LOW;
   wire       mod_en  = mclk_rise && (div_cnt_q == div_n - 5'd1);

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N)
         div_cnt_q <= 5'd0;
      // a divisor cut mid-count wraps at once instead of running past
      else if (mclk_rise)
         div_cnt_q <= (div_cnt_q >= div_n - 5'd1) ? 5'd0 : div_cnt_q + 5'd1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // decimation ratio per rate code; codes 6 and 7 both give the fastest rate
   reg  [11:0] dec_cnt_q;

   function [11:0] dec_ratio;
      input [2:0] code;
      begin
         case (code)
            3'h0:    dec_ratio = 12'h400;
            3'h1:    dec_ratio = 12'h200;
            3'h2:    dec_ratio = 12'h100;
            3'h3:    dec_ratio = 12'h080;
            3'h4:    dec_ratio = 12'h040;
            3'h5:    dec_ratio = 12'h020;
            default: dec_ratio = 12'h010;
         endcase
      end
   endfunction

   // gain is N cubed; with three guard bits the right shift is 3*log2(N) - 12
   function [4:0] gain_shift;
      input [2:0] code;
      begin
         case (code)
            3'h0:    gain_shift = 5'h12;
            3'h1:    gain_shift = 5'h0F;
            3'h2:    gain_shift = 5'h0C;
            3'h3:    gain_shift = 5'h09;
            3'h4:    gain_shift = 5'h06;
            3'h5:    gain_shift = 5'h03;
            default: gain_shift = 5'h00;
         endcase
      end
   endfunction

   wire [11:0] dec_n    = dec_ratio(data_rate_code);
   wire [4:0]  shift    = gain_shift(data_rate_code);
   wire        dec_tick = mod_en && (dec_cnt_q >= dec_n - 12'h001);

   // start edge restarts the period count
   // START and the software start bit both low stops publishing; the next rise starts settling again
   reg  start_q;
   wire start_lvl  = START || sw_start_q;
   wire start_rise = start_lvl && !start_q;
   reg  running_q;
   reg  [1:0] settle_q;

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         dec_cnt_q <= 12'h000;
         start_q   <= 1'b0;
         running_q <= 1'b0;
         settle_q  <= 2'd0;
      end else begin
         start_q <= start_lvl;
         if (start_rise) begin
            dec_cnt_q <= 12'h000;
            running_q <= 1'b1;
            settle_q  <= 2'd0;
         end else if (!start_lvl) begin
            running_q <= 1'b0;
         end else if (mod_en) begin
            dec_cnt_q <= dec_tick ? 12'h000 : dec_cnt_q + 12'h001;
            // counter saturates, so every later period publishes
            // RULE_05 RULE_06 hold off three periods
            if (dec_tick && settle_q != `SETTLE_PERIODS)
               settle_q <= settle_q + 2'd1;
         end
      end
   end

   wire publish = running_q && dec_tick && (settle_q == `SETTLE_PERIODS);

   ////////////////////////////////////////////////////////////////////////////
   // channels
   wire [16*NCH-1:0] res;
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : ch
         // RULE_03 RULE_04 RULE_12 RULE_13 shared ratio
         sinc3_channel #(.ACC_W(ACC_W)) u_ch (
            .clk      (CLK_SYS),
            .rst_n    (RST_N),
            .mod_en   (mod_en),
            .mod_bit  (MOD_BITS[g]),
            .dec_tick (dec_tick),
            .shift    (shift),
            .result_q (res[16*g+15:16*g])
         );
      end
   endgenerate

   // one cycle late so channel results are fresh
   // channel registers move on every tick; SAMPLES only on publish
   reg publish_q;
   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         publish_q          <= 1'b0;
         SAMPLES            <= {16*NCH{1'b0}};
         CONVERSION_READY_N <= 1'b1;
      end else begin
         publish_q <= publish;
         if (publish_q) begin
            // RULE_18 RULE_11 latch all words together
            SAMPLES            <= res;
            // RULE_17 ready falls
            CONVERSION_READY_N <= 1'b0;
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            // any read handshake acknowledges the ready strobe
            CONVERSION_READY_N <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path
   // status: ready, running, external clock, software start
   wire [31:0] status_word = {28'h0000000, CONVERSION_READY_N, running_q, ext_mode, sw_start_q};
   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= 32'h00000000;
         S_AXI_RRESP  <= 2'b00;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP  <= mapped(S_AXI_ARADDR) ? 2'b00 : 2'b10;
         case (S_AXI_ARADDR)
            `OFS_PRIMARY_CONFIG: S_AXI_RDATA <= {24'h000000, primary_config_register_q};
            `OFS_SECOND_CONFIG:  S_AXI_RDATA <= {24'h000000, second_config_register_q};
            `OFS_THIRD_CONFIG:   S_AXI_RDATA <= {24'h000000, third_config_register_q};
            `OFS_LEADOFF_STATUS: S_AXI_RDATA <= {24'h000000, leadoff_status_register_q};
            `OFS_STATUS:         S_AXI_RDATA <= status_word;
            `OFS_SAMPLE:         S_AXI_RDATA <= SAMPLES[31:0];
            default:             S_AXI_RDATA <= 32'h00000000;
         endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end
endmodule // sinc3_decimator_clocking

/* File: verif/mclk_source.sv */
// master clock source feeding the oscillator input and the clock pin
module mclk_source (
   // control
   input  logic run,
   // clock
   output logic mclk
);
   timeunit 1ns;
   timeprecision 1ps;
   initial mclk = 1'b0;
   // stops when idle
   // edges land on falling system clock edges, so sampling never races
   always #16 if (run) mclk = ~mclk;
endmodule // mclk_source

/* File: verif/sinc3_decimator_clocking_sva.sv */
// port assertions for the sinc3 decimator and clocking block
module sinc3_decimator_clocking_sva #(
   parameter NCH = 2
) (
   // system and bus
   input logic              CLK_SYS,
   input logic              RST_N,
   input logic              S_AXI_BVALID,
   input logic [1:0]        S_AXI_BRESP,
   input logic              S_AXI_BREADY,
   input logic              S_AXI_ARVALID,
   input logic              S_AXI_ARREADY,
   input logic              S_AXI_RVALID,
   input logic              S_AXI_RREADY,
   input logic [31:0]       S_AXI_RDATA,
   // clocking and reference
   input logic              CLOCK_SOURCE_PIN,
   input logic              MCLK_INT,
   input logic              CLK_PIN_O,
   input logic              CLK_PIN_OE_N,
   input logic              REFBUF_POWER,
   input logic              HIGH_REFERENCE_SELECT,
   // samples
   input logic [16*NCH-1:0] SAMPLES,
   input logic              CONVERSION_READY_N
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   property p_ref_rst;
      $rose(RST_N) |-> !REFBUF_POWER && !HIGH_REFERENCE_SELECT;
   endproperty
   a_ref_rst: assert property (p_ref_rst)
      else $error("reference outputs on after reset");
   property p_ext_float;
      !CLOCK_SOURCE_PIN |=> CLK_PIN_OE_N;
   endproperty
   a_ext_float: assert property (p_ext_float)
      else $error("clock pin driven in external mode");
   property p_clk_copy;
      !CLK_PIN_OE_N |-> CLK_PIN_O == $past(MCLK_INT);
   endproperty
   a_clk_copy: assert property (p_clk_copy)
      else $error("clock pin not the oscillator");
   property p_rdy_hold;
      !CONVERSION_READY_N && !(S_AXI_RVALID && S_AXI_RREADY) |=> !CONVERSION_READY_N;
   endproperty
   a_rdy_hold: assert property (p_rdy_hold)
      else $error("ready released without a read");
   property p_set_together;
      $changed(SAMPLES) |-> ##[0:1] !CONVERSION_READY_N;
   endproperty
   a_set_together: assert property (p_set_together)
      else $error("samples changed without ready");
   property p_rd_lat;
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read answer late");
   property p_rd_hold;
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read answer dropped");
   property p_ar_block;
      S_AXI_RVALID |-> !S_AXI_ARREADY;
   endproperty
   a_ar_block: assert property (p_ar_block)
      else $error("second read taken");
   property p_wr_hold;
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
   endproperty
   a_wr_hold: assert property (p_wr_hold)
      else $error("write answer dropped");
endmodule // sinc3_decimator_clocking_sva
bind sinc3_decimator_clocking sinc3_decimator_clocking_sva #(.NCH(NCH)) sva_i (.*);

/* File: verif/sinc3_decimator_clocking_tb.sv */
// self-checking bench for the sinc3 decimator and clocking block
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module sinc3_decimator_clocking_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [33:0] skip_e = '1;
   logic clk_sys = 0, rst_n = 0, src = 1, start = 0, rnd = 0, run = 1;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, samples;
   logic [1:0] mod_bits = 2'b00, lvl = 2'b00, bresp, rresp;
   logic [33:0] e_q[$], e;
   wire awready, wready, bvalid, arready, rvalid, mclk, pin_o, pin_oe_n, refbuf, href, ready_n;
   int cyc = 0, n_errors = 0, samples_checked = 0;
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cyc <= cyc + 1;
   // random bits until the step, then a fixed level per channel
   always @(posedge clk_sys) mod_bits <= rnd ? 2'($urandom) : lvl;
   mclk_source mclk_source_i (.run(run), .mclk(mclk));
   sinc3_decimator_clocking #(.NCH(2)) sinc3_decimator_clocking_i (
      .CLK_SYS(clk_sys), .RST_N(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .CLOCK_SOURCE_PIN(src), .MCLK_EXT(1'b0), .MCLK_INT(mclk),
      .CLK_PIN_I(pin_oe_n ? mclk : pin_o), .CLK_PIN_O(pin_o), .CLK_PIN_OE_N(pin_oe_n),
      .START(start), .MOD_BITS(mod_bits), .REFBUF_POWER(refbuf),
      .HIGH_REFERENCE_SELECT(href), .SAMPLES(samples), .CONVERSION_READY_N(ready_n));
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys) begin
      if (rvalid && rready && e_q.size() > 0) begin
         e = e_q.pop_front();
         if (e !== skip_e) `CHK("read", e, {rresp, rdata})
      end
   end
   task give_verdict();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic bound(input int n, input int lim);
      if (n >= lim) begin
         n_errors++;
         give_verdict();
      end
   endtask
   // register traffic is paced by the system clock alone
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n = 0;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (!bready) bready <= 1'($urandom);
         n++;
      end while (!(bvalid && bready) && n < 50);
      bready <= 1'b0;
      bound(n, 50);
      `CHK("bresp", 2'b00, bresp)
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] x);
      int n = 0;
      @(posedge clk_sys);
      e_q.push_back(x);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'b0;
         if (!rready) rready <= 1'($urandom);
         n++;
      end while (!(rvalid && rready) && n < 50);
      rready <= 1'b0;
      bound(n, 50);
   endtask
   task automatic take(input logic [33:0] x);
      rd(8'h14, x);
      @(posedge clk_sys);
      `CHK("ready_n", 1'b1, ready_n)
   endtask
   task automatic wait_rdy(output int t);
      int n = 0;
      @(posedge clk_sys);
      while (ready_n !== 1'b0 && n < 30000) begin
         @(posedge clk_sys);
         n++;
      end
      bound(n, 30000);
      t = cyc;
   endtask
   // master clock is 8 system cycles, so a period is N * divisor * 8
   task automatic conv(input logic [2:0] c, input logic dv, input logic s,
                       input logic [1:0] l, input logic [31:0] x);
      int t0, t1, t2, per;
      per = (16 << (6 - c)) * (dv ? 16 : 4) * 8;
      wr(8'h00, {3'b001, 2'b00, c});
      wr(8'h0C, {1'b0, dv, 6'h00});
      src <= s;
      rnd <= 1'b1;
      // the slow divisor run starts from software, the others from the pin
      if (dv) begin
         wr(8'h10, 8'h01);
         rd(8'h10, 34'h00D);
      end else begin
         start <= 1'b1;
      end
      t0 = cyc;
      wait_rdy(t1);
      `CHK("settle", 1'b1, (t1 - t0 >= 3 * per))
      take(skip_e);
      wait_rdy(t2);
      `CHK("period", per, t2 - t1)
      rnd <= 1'b0;
      lvl <= l;
      repeat (4) begin
         take(skip_e);
         wait_rdy(t2);
      end
      take({2'b00, x});
      if (dv) wr(8'h10, 8'h00);
      else start <= 1'b0;
      $display("conversion code %0d div %0d done", c, dv);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(15684));
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(8'h00, 34'h002);
      rd(8'h04, 34'h080);
      rd(8'h08, 34'h000);
      rd(8'h0C, 34'h000);
      rd(8'h3C, {2'b10, 32'h0});
      `CHK("refbuf", 1'b0, refbuf)
      `CHK("href", 1'b0, href)
      wr(8'h08, 8'h80);
      wr(8'h04, 8'hA0);
      repeat (2) @(posedge clk_sys);
      `CHK("refbuf", 1'b1, refbuf)
      `CHK("href", 1'b1, href)
      $display("register test done");
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, {2'b00, i[0], 5'h06});
         src <= i[1];
         repeat (3) @(posedge clk_sys);
         `CHK("clk_oe_n", ~(i[1] & i[0]), pin_oe_n)
      end
      $display("clock pin test done");
      conv(3'd6, 1'b0, 1'b1, 2'b01, 32'h8000_7FFF);
      conv(3'd5, 1'b0, 1'b0, 2'b10, 32'h7FFF_8000);
      conv(3'd6, 1'b1, 1'b1, 2'b11, 32'h7FFF_7FFF);
      give_verdict();
   end
endmodule // sinc3_decimator_clocking_tb
